// [core/scan_defines.svh]
// shared offsets, opcodes and timing counts of the scan port
`ifndef SCAN_DEFINES_SVH
`define SCAN_DEFINES_SVH
`define IR_W                    4
`define IR_CAPTURE              4'h1
`define OP_EXTEST               4'h0
`define OP_SAMPLE               4'h1
`define OP_ID                   4'h6
`define OP_USER                 4'h7
`define OP_SIGN                 4'h8
`define OP_ADDR                 4'h9
`define OP_PROG                 4'hA
`define OP_VERIFY               4'hB
`define OP_ERASE                4'hC
`define OP_BYPASS               4'hF
`define SIGN_WORD               0
`define USER_WORD               1
`define ERASED_WORD             32'hFFFF_FFFF
`define CORE_CLK_MHZ            125
`define PROGRAM_PULSE_TOTAL_US  100
`define VERIFY_PULSE_TOTAL_US   20
`define TCK_DIV                 8
`define SEQ_W                   48
`endif

// [core/scan_pkg.sv]
// types for the tap states, the controller commands and the controller states
package scan_pkg;
   typedef enum logic [3:0] {
      TLR    = 4'b0000, RTI    = 4'b0001, SEL_DR = 4'b0010, CAP_DR = 4'b0011,
      SH_DR  = 4'b0100, EX1_DR = 4'b0101, PAU_DR = 4'b0110, EX2_DR = 4'b0111,
      UPD_DR = 4'b1000, SEL_IR = 4'b1001, CAP_IR = 4'b1010, SH_IR  = 4'b1011,
      EX1_IR = 4'b1100, PAU_IR = 4'b1101, EX2_IR = 4'b1110, UPD_IR = 4'b1111
   } tap_state_type;
   typedef enum logic [2:0] {
      CMD_RESET        = 3'b000,
      CMD_IR           = 3'b001,
      CMD_DR           = 3'b010,
      CMD_PULSE_PROG   = 3'b011,
      CMD_PULSE_VERIFY = 3'b100
   } cmd_kind_type;
   typedef enum logic [1:0] {
      C_IDLE  = 2'b00,
      C_SHIFT = 2'b01,
      C_WAIT  = 2'b10
   } ctl_state_type;
endpackage

// [core/scan_link_if.sv]
// serial test link between the controller and the scan port
`timescale 1ns/1ps
interface scan_link_if;
   logic tck;        // test clock, made by the controller
   logic tms;        // mode select
   logic tdi;        // serial data toward the port
   logic trst_n;     // test reset, sampled on tck
   logic tdo;        // serial data from the port
   logic tdo_oe_n;   // port drives tdo while low
   wire  tdo_line;   // resolved pin level, pulled high when released
   assign tdo_line = tdo_oe_n ? 1'b1 : tdo;
   modport device (input tck, input tms, input tdi, input trst_n,
                   output tdo, output tdo_oe_n);
   modport controller (output tck, output tms, output tdi, output trst_n,
                       input tdo_line);
endinterface

// [core/scan_port.sv]
// scan port end: tap controller, instructions, data registers, cells
`timescale 1ns/1ps
`include "scan_defines.svh"
module scan_port #(
   parameter int          PINS     = 8,
   parameter int          CELLS    = 16,
   parameter int          ADDR_W   = 4,
   parameter logic [31:0] ID_CODE  = 32'h1000_0001, // arbitrary value
   parameter bit          HAS_USER = 1'b1,
   parameter bit          HAS_SIGN = 1'b1
) (
   scan_link_if.device           link,
   input  wire logic             core_clk,
   input  wire logic             resetn,
   input  wire logic [PINS-1:0]  core_out,
   input  wire logic [PINS-1:0]  pin_in,
   output logic      [PINS-1:0]  pin_out,
   output logic                  prog_active
);
   import scan_pkg::*;

   // link clock domain
   tap_state_type          tap_q;           // controller state
   tap_state_type          tap_d;
   logic [`IR_W-1:0]       ir_sh_q;         // instruction shift stage
   logic [`IR_W-1:0]       ir_q;            // active instruction
   logic [31:0]            dr_q;            // shared data shift stage
   logic [31:0]            dr_shifted;      // dr_q after one shift
   logic [31:0]            cap_val;         // value loaded on capture
   logic [4:0]             dr_msb;          // selected register length - 1
   logic [PINS-1:0]        upd_q;           // boundary update latch
   logic                   upd_tgl_q;       // flips on each boundary update
   logic                   ext_mode_q;      // external test active
   logic                   isp_mode_q;      // programming instruction active
   logic [ADDR_W-1:0]      addr_q;          // cell address
   logic [31:0]            cells_q [CELLS]; // nonvolatile words, no reset
   logic [PINS-1:0]        pins_seen_q;     // agreed pin levels
   logic [PINS-1:0]        pin_s1_q;
   logic [PINS-1:0]        pin_s2_q;
   logic [PINS-1:0]        pin_s3_q;
   logic                   tdo_q;
   logic                   tdo_oe_n_q;

   // decode of the active instruction; anything unknown falls to bypass
   wire sel_extest = (ir_q == `OP_EXTEST);
   wire sel_sample = (ir_q == `OP_SAMPLE);
   wire sel_id     = (ir_q == `OP_ID);
   wire sel_user   = (ir_q == `OP_USER) && HAS_USER;
   wire sel_sign   = (ir_q == `OP_SIGN) && HAS_SIGN;
   wire sel_addr   = (ir_q == `OP_ADDR);
   wire sel_prog   = (ir_q == `OP_PROG);
   wire sel_verify = (ir_q == `OP_VERIFY);
   wire sel_erase  = (ir_q == `OP_ERASE);
   wire sel_bscan  = sel_extest | sel_sample;
   wire sel_cell   = sel_prog | sel_verify;
   wire sel_bypass = !(sel_bscan | sel_id | sel_user | sel_sign | sel_addr
                       | sel_cell | sel_erase);
   wire ir_is_isp  = (ir_sh_q == `OP_ADDR) || (ir_sh_q == `OP_PROG)
                     || (ir_sh_q == `OP_VERIFY) || (ir_sh_q == `OP_ERASE);

   // length of the register now between tdi and tdo
   assign dr_msb = sel_bypass ? 5'd0 :
                   sel_bscan  ? 5'(PINS - 1) :
                   sel_addr   ? 5'(ADDR_W - 1) : 5'd31;

   // capture source per instruction
   assign cap_val = sel_bscan  ? 32'(pins_seen_q) :
                    sel_id     ? ID_CODE :
                    sel_user   ? cells_q[`USER_WORD] :
                    sel_sign   ? cells_q[`SIGN_WORD] :
                    sel_addr   ? 32'(addr_q) :
                    sel_cell   ? cells_q[addr_q] :
                    32'h0000_0000;

   // tdi enters at the top of the selected length
   always_comb begin
      dr_shifted         = {1'b0, dr_q[31:1]};
      dr_shifted[dr_msb] = link.tdi;
   end

   // next state of the tap controller
   always_comb begin
      unique case (tap_q)
         TLR:    tap_d = link.tms ? TLR    : RTI;
         RTI:    tap_d = link.tms ? SEL_DR : RTI;
         SEL_DR: tap_d = link.tms ? SEL_IR : CAP_DR;
         CAP_DR: tap_d = link.tms ? EX1_DR : SH_DR;
         SH_DR:  tap_d = link.tms ? EX1_DR : SH_DR;
         EX1_DR: tap_d = link.tms ? UPD_DR : PAU_DR;
         PAU_DR: tap_d = link.tms ? EX2_DR : PAU_DR;
         EX2_DR: tap_d = link.tms ? UPD_DR : SH_DR;
         UPD_DR: tap_d = link.tms ? SEL_DR : RTI;
         SEL_IR: tap_d = link.tms ? TLR    : CAP_IR;
         CAP_IR: tap_d = link.tms ? EX1_IR : SH_IR;
         SH_IR:  tap_d = link.tms ? EX1_IR : SH_IR;
         EX1_IR: tap_d = link.tms ? UPD_IR : PAU_IR;
         PAU_IR: tap_d = link.tms ? EX2_IR : PAU_IR;
         EX2_IR: tap_d = link.tms ? UPD_IR : SH_IR;
         UPD_IR: tap_d = link.tms ? SEL_DR : RTI;
      endcase
   end

   // tap state, test reset wins
   always_ff @(posedge link.tck) begin
      if (!link.trst_n) begin
         tap_q <= TLR;
      end else begin
         tap_q <= tap_d;
      end
   end

   // instruction path: capture fixed pattern, shift, update
   always_ff @(posedge link.tck) begin
      if (!link.trst_n || tap_q == TLR) begin
         ir_sh_q    <= `IR_CAPTURE;
         ir_q       <= `OP_ID;
         ext_mode_q <= 1'b0;
         isp_mode_q <= 1'b0;
      end else begin
         unique case (tap_q)
            CAP_IR:  ir_sh_q <= `IR_CAPTURE;
            SH_IR:   ir_sh_q <= {link.tdi, ir_sh_q[`IR_W-1:1]};
            UPD_IR: begin
               ir_q       <= ir_sh_q;
               ext_mode_q <= (ir_sh_q == `OP_EXTEST);
               isp_mode_q <= ir_is_isp;
            end
            default: ir_sh_q <= ir_sh_q; // other states hold
         endcase
      end
   end

   // data path and update actions
   always_ff @(posedge link.tck) begin
      if (!link.trst_n) begin
         dr_q      <= 32'h0000_0000;
         upd_q     <= '0;
         upd_tgl_q <= 1'b0;
         addr_q    <= '0;
      end else begin
         if (tap_q == CAP_DR) begin
            dr_q <= cap_val;
         end else if (tap_q == SH_DR) begin
            dr_q <= dr_shifted;
         end
         if (tap_q == UPD_DR && sel_bscan) begin
            upd_q     <= dr_q[PINS-1:0];
            upd_tgl_q <= !upd_tgl_q;
         end
         if (tap_q == UPD_DR && sel_addr) begin
            addr_q <= dr_q[ADDR_W-1:0];
         end
      end
   end

   // cells change only on update, so a half-shifted word never lands
   always_ff @(posedge link.tck) begin
      for (int i = 0; i < CELLS; i++) begin
         if (link.trst_n && tap_q == UPD_DR && sel_erase) begin
            cells_q[i] <= `ERASED_WORD;
         end else if (link.trst_n && tap_q == UPD_DR && sel_prog
                      && addr_q == ADDR_W'(i)) begin
            cells_q[i] <= dr_q;
         end
      end
   end

   // pins sampled on tck; a level counts once two stages agree
   always_ff @(posedge link.tck) begin
      if (!link.trst_n) begin
         pin_s1_q    <= '0;
         pin_s2_q    <= '0;
         pin_s3_q    <= '0;
         pins_seen_q <= '0;
      end else begin
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         for (int i = 0; i < PINS; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) begin
               pins_seen_q[i] <= pin_s3_q[i];
            end
         end
      end
   end

   // tdo changes on the falling edge, so the controller samples it at bit end
   always_ff @(negedge link.tck) begin
      if (!link.trst_n) begin
         tdo_q      <= 1'b0;
         tdo_oe_n_q <= 1'b1;
      end else begin
         tdo_q      <= (tap_q == SH_IR) ? ir_sh_q[0] : dr_q[0];
         tdo_oe_n_q <= !(tap_q == SH_IR || tap_q == SH_DR);
      end
   end
   assign link.tdo      = tdo_q;
   assign link.tdo_oe_n = tdo_oe_n_q;

   // core clock domain
   logic [2:0]      ext_s_q;  // external test mode sync
   logic [2:0]      isp_s_q;  // programming mode sync
   logic [2:0]      tgl_s_q;  // update toggle sync
   logic            ext_q;
   logic            isp_q;
   logic            tgl_seen_q;
   logic [PINS-1:0] upd_core_q;
   logic [PINS-1:0] pin_out_q;

   // upd_q is stable well before its toggle is seen here
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ext_s_q    <= 3'h0;
         isp_s_q    <= 3'h0;
         tgl_s_q    <= 3'h0;
         ext_q      <= 1'b0;
         isp_q      <= 1'b0;
         tgl_seen_q <= 1'b0;
         upd_core_q <= '0;
         pin_out_q  <= '0;
      end else begin
         ext_s_q <= {ext_s_q[1:0], ext_mode_q};
         isp_s_q <= {isp_s_q[1:0], isp_mode_q};
         tgl_s_q <= {tgl_s_q[1:0], upd_tgl_q};
         if (ext_s_q[1] == ext_s_q[2]) begin
            ext_q <= ext_s_q[2];
         end
         if (isp_s_q[1] == isp_s_q[2]) begin
            isp_q <= isp_s_q[2];
         end
         if (tgl_s_q[1] == tgl_s_q[2] && tgl_s_q[2] != tgl_seen_q) begin
            tgl_seen_q <= tgl_s_q[2];
            upd_core_q <= upd_q;
         end
         // normal logic keeps the pins unless external test owns them
         pin_out_q <= ext_q ? upd_core_q : core_out;
      end
   end
   assign pin_out     = pin_out_q;
   assign prog_active = isp_q;
endmodule // scan_port

// [core/scan_controller.sv]
// controller end: makes tck, walks the tap, times programming pulses
`timescale 1ns/1ps
`include "scan_defines.svh"
module scan_controller #(
   parameter int DIV        = `TCK_DIV,
   parameter int PROG_PULSE = `PROGRAM_PULSE_TOTAL_US * `CORE_CLK_MHZ,
   parameter int VER_PULSE  = `VERIFY_PULSE_TOTAL_US * `CORE_CLK_MHZ
) (
   scan_link_if.controller        link,
   input  wire logic              core_clk,
   input  wire logic              resetn,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire scan_pkg::cmd_kind_type cmd_kind,
   input  wire logic [5:0]        cmd_len,
   input  wire logic [31:0]       cmd_data,
   output logic                   rsp_valid,
   output logic [31:0]            rsp_data,
   output logic [31:0]            program_shift_cycles,
   output logic [31:0]            budget_cycles
);
   import scan_pkg::*;
   localparam int PH_W = $clog2(DIV);

   ctl_state_type        st_q;
   logic [PH_W-1:0]      phase_q;    // position inside one tck period
   logic                 tck_q;
   logic                 tms_q;
   logic                 tdi_q;
   logic                 trst_n_q;
   logic [`SEQ_W-1:0]    tms_v;      // per-bit tms for a command
   logic [`SEQ_W-1:0]    tdi_v;
   logic [`SEQ_W-1:0]    cap_v;      // bits whose tdo is kept
   logic [5:0]           n_v;        // bits in the command
   logic [`SEQ_W-1:0]    tms_s_q;
   logic [`SEQ_W-1:0]    tdi_s_q;
   logic [`SEQ_W-1:0]    cap_s_q;
   logic [5:0]           n_q;
   logic [5:0]           idx_q;
   logic [5:0]           len_q;
   logic                 rst_cmd_q;  // test reset held for this command
   logic [31:0]          rsp_q;
   logic [31:0]          rsp_data_q;
   logic                 rsp_valid_q;
   logic [31:0]          wait_q;     // pulse cycles left
   logic [31:0]          shift_cnt_q;
   logic [31:0]          budget_q;
   logic [2:0]           tdo_s_q;
   logic                 tdo_seen_q;

   wire ph_last = (phase_q == PH_W'(DIV - 1));
   wire ph_rise = (phase_q == PH_W'(DIV / 2 - 1)); // last cycle before rise
   wire [5:0] len_eff = (cmd_len == 6'h00) ? 6'h01 :
                        (cmd_len > 6'h20) ? 6'h20 : cmd_len;
   assign cmd_ready = (st_q == C_IDLE) && ph_last;
   wire take = cmd_valid && cmd_ready;

   // bit sequence for one command, first bit at index 0
   always_comb begin
      int pre;
      int len;
      pre   = (cmd_kind == CMD_IR) ? 4 : 3;
      len   = int'(len_eff);
      tms_v = '0;
      tdi_v = '0;
      cap_v = '0;
      n_v   = 6'(pre + len + 2);
      if (cmd_kind == CMD_RESET) begin
         tms_v = `SEQ_W'(5'h1F); // five ones then idle
         n_v   = 6'h06;
      end else begin
         for (int i = 0; i < `SEQ_W; i++) begin
            if (i < pre) begin
               tms_v[i] = (cmd_kind == CMD_IR) ? (i < 2) : (i == 0);
            end else if (i < pre + len) begin
               tms_v[i] = (i == pre + len - 1);
               tdi_v[i] = cmd_data[(i - pre) % 32];
               cap_v[i] = 1'b1;
            end else if (i == pre + len) begin
               tms_v[i] = 1'b1; // update
            end
         end
      end
   end

   // tck divider, free running
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         phase_q <= '0;
         tck_q   <= 1'b0;
      end else begin
         phase_q <= ph_last ? '0 : phase_q + PH_W'(1);
         tck_q   <= ph_last ? 1'b0 : (ph_rise ? 1'b1 : tck_q);
      end
   end

   // tdo from the port's clock, counted once two stages agree
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tdo_s_q    <= 3'h7;
         tdo_seen_q <= 1'b1;
      end else begin
         tdo_s_q <= {tdo_s_q[1:0], link.tdo_line};
         if (tdo_s_q[1] == tdo_s_q[2]) begin
            tdo_seen_q <= tdo_s_q[2];
         end
      end
   end

   // command sequencer; pins change only as tck falls
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st_q <= C_IDLE; tms_q <= 1'b0; tdi_q <= 1'b0; trst_n_q <= 1'b0;
         tms_s_q <= '0; tdi_s_q <= '0; cap_s_q <= '0; rst_cmd_q <= 1'b0;
         n_q <= 6'h00; idx_q <= 6'h00; len_q <= 6'h01; rsp_q <= 32'h0;
         rsp_data_q <= 32'h0; rsp_valid_q <= 1'b0; wait_q <= 32'h0;
         shift_cnt_q <= 32'h0; budget_q <= 32'h0;
      end else begin
         rsp_valid_q <= 1'b0;
         unique case (st_q)
            C_IDLE: if (take) begin
               if (cmd_kind == CMD_PULSE_PROG || cmd_kind == CMD_PULSE_VERIFY) begin
                  // cells need a fixed settle time, tms low keeps idle
                  wait_q <= (cmd_kind == CMD_PULSE_PROG) ? 32'(PROG_PULSE)
                                                         : 32'(VER_PULSE);
                  budget_q <= budget_q + ((cmd_kind == CMD_PULSE_PROG)
                              ? 32'(PROG_PULSE) : 32'(VER_PULSE));
                  st_q <= C_WAIT;
               end else begin
                  tms_s_q   <= tms_v;
                  tdi_s_q   <= tdi_v;
                  cap_s_q   <= cap_v;
                  n_q       <= n_v;
                  len_q     <= len_eff;
                  idx_q     <= 6'h00;
                  tms_q     <= tms_v[0];
                  tdi_q     <= tdi_v[0];
                  rst_cmd_q <= (cmd_kind == CMD_RESET);
                  trst_n_q  <= (cmd_kind != CMD_RESET) && trst_n_q;
                  if (cmd_kind == CMD_RESET) begin
                     shift_cnt_q <= 32'h0;
                     budget_q    <= 32'h0;
                  end
                  st_q <= C_SHIFT;
               end
            end
            C_SHIFT: begin
               // tdo_seen_q only settles at the rise edge itself, so sample at bit end
               if (ph_last && cap_s_q[idx_q]) begin
                  rsp_q <= {tdo_seen_q, rsp_q[31:1]};
               end
               if (ph_last) begin
                  shift_cnt_q <= shift_cnt_q + 32'h1;
                  budget_q    <= budget_q + 32'(DIV);
                  if (idx_q == n_q - 6'h01) begin
                     tms_q       <= 1'b0;
                     tdi_q       <= 1'b0;
                     trst_n_q    <= trst_n_q | rst_cmd_q;
                     rsp_data_q  <= rsp_q >> (6'h20 - len_q);
                     rsp_valid_q <= 1'b1;
                     st_q        <= C_IDLE;
                  end else begin
                     idx_q <= idx_q + 6'h01;
                     tms_q <= tms_s_q[idx_q + 6'h01];
                     tdi_q <= tdi_s_q[idx_q + 6'h01];
                  end
               end
            end
            C_WAIT: begin
               wait_q <= wait_q - 32'h1;
               if (wait_q <= 32'h1) begin
                  rsp_data_q  <= 32'h0;
                  rsp_valid_q <= 1'b1;
                  st_q        <= C_IDLE;
               end
            end
            default: st_q <= C_IDLE;
         endcase
      end
   end

   assign link.tck             = tck_q;
   assign link.tms             = tms_q;
   assign link.tdi             = tdi_q;
   assign link.trst_n          = trst_n_q;
   assign rsp_valid            = rsp_valid_q;
   assign rsp_data             = rsp_data_q;
   assign program_shift_cycles = shift_cnt_q;
   assign budget_cycles        = budget_q;
endmodule // scan_controller

// [verif/scan_link_asserts.sv]
// concurrent checks on the serial test link between the two ends
`timescale 1ns/1ps
`include "scan_defines.svh"
module scan_link_asserts
   import scan_pkg::*;
#(
   parameter logic [31:0] ID_CODE = 32'h1000_0001 // arbitrary value
) (
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   input wire logic tdo,
   input wire logic tdo_oe_n,
   input wire logic tdo_line
);
   tap_state_type st_q;  // shadow tap state
   logic [5:0]    cnt_q; // bits already shifted in this shift state
   logic [3:0]    sh_q;  // instruction image being shifted
   logic [3:0]    ir_q;  // instruction in force
   wire           shift_w = (st_q == SH_DR) || (st_q == SH_IR);
   // unknown codes must behave as the one-bit path
   wire           byp_w   = !(ir_q inside {4'h0, 4'h1, [4'h6:4'hC]});

   // standard sixteen-state walk, tms sampled on the rising edge
   function automatic tap_state_type nxt(input tap_state_type s, input logic m);
      case (s)
         TLR:                 return m ? TLR : RTI;
         RTI, UPD_DR, UPD_IR: return m ? SEL_DR : RTI;
         SEL_DR:              return m ? SEL_IR : CAP_DR;
         CAP_DR, SH_DR:       return m ? EX1_DR : SH_DR;
         EX1_DR:              return m ? UPD_DR : PAU_DR;
         PAU_DR:              return m ? EX2_DR : PAU_DR;
         EX2_DR:              return m ? UPD_DR : SH_DR;
         SEL_IR:              return m ? TLR : CAP_IR;
         CAP_IR, SH_IR:       return m ? EX1_IR : SH_IR;
         EX1_IR:              return m ? UPD_IR : PAU_IR;
         PAU_IR:              return m ? EX2_IR : PAU_IR;
         default:             return m ? UPD_IR : SH_IR;
      endcase
   endfunction

   // shadow model; no pause handling, the controller never pauses
   always_ff @(posedge tck) begin
      if (!trst_n) begin
         st_q  <= TLR;
         cnt_q <= 6'h00;
         sh_q  <= 4'h0;
         ir_q  <= `OP_ID;
      end else begin
         st_q  <= nxt(st_q, tms);
         cnt_q <= shift_w ? cnt_q + 6'h01 : 6'h00;
         sh_q  <= (st_q == SH_IR) ? {tdi, sh_q[3:1]} : sh_q;
         ir_q  <= (st_q == UPD_IR) ? sh_q : ((st_q == TLR) ? `OP_ID : ir_q);
      end
   end

   default clocking cb @(posedge tck); endclocking
   default disable iff (!trst_n);

   sequence s_dr_entry;
      (st_q == CAP_DR) ##1 (st_q == SH_DR);
   endsequence

   chk_oe_shift: assert property (tdo_oe_n == !shift_w)
      else $error("tdo enable does not follow the shift states");
   chk_dr_enable: assert property (s_dr_entry |-> !tdo_oe_n)
      else $error("tdo not driven on entry to data shift");
   chk_ir_cap_one: assert property ((st_q == SH_IR && cnt_q == 6'h00) |-> tdo)
      else $error("first instruction capture bit not one");
   chk_ir_cap_zero: assert property ((st_q == SH_IR && cnt_q inside {[1:3]}) |-> !tdo_line)
      else $error("upper instruction capture bits not zero");
   chk_ir_pass: assert property ((st_q == SH_IR && cnt_q >= 6'h04)
      |-> tdo_line == $past(tdi, 4))
      else $error("instruction path is not four bits deep");
   chk_byp_zero: assert property ((st_q == SH_DR && byp_w && cnt_q == 6'h00) |-> !tdo_line)
      else $error("one-bit path did not capture zero");
   chk_byp_pass: assert property ((st_q == SH_DR && byp_w && cnt_q != 6'h00)
      |-> tdo_line == $past(tdi))
      else $error("one-bit path delay wrong");
   chk_id_bits: assert property ((st_q == SH_DR && ir_q == `OP_ID && cnt_q < 6'd32)
      |-> tdo_line == ID_CODE[cnt_q[4:0]])
      else $error("identification bit wrong");
endmodule // scan_link_asserts

// [verif/tb_boundary_scan_instruction_set.sv]
// self-checking bench: controller and scan port joined by the link
`timescale 1ns/1ps
`include "scan_defines.svh"
module tb_boundary_scan_instruction_set;
   import scan_pkg::*;
   localparam int          PINS = 8;
   localparam logic [31:0] IDC  = 32'h2000_0003; // arbitrary value
   localparam int          PP   = 30;            // short program pulse for sim
   localparam int          VP   = 20;            // short verify pulse for sim
   logic            core_clk, resetn, cmd_valid, cmd_ready, rsp_valid, prog_active;
   cmd_kind_type    cmd_kind;
   logic [5:0]      cmd_len;
   logic [31:0]     cmd_data, rsp_data, shift_cnt, budget, d, w;
   logic [PINS-1:0] core_out, pin_in, pin_out, p, q;
   logic [3:0]      ops [3] = '{4'hF, 4'h3, 4'hD};
   int n_mismatch = 0, n_compared = 0, seed = 32'h0040, shifts = 0, pulses = 0;

   scan_link_if link ();
   scan_controller #(.PROG_PULSE(PP), .VER_PULSE(VP)) scan_controller_i (.link(link),
      .core_clk(core_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_kind(cmd_kind), .cmd_len(cmd_len), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .program_shift_cycles(shift_cnt), .budget_cycles(budget));
   scan_port #(.ID_CODE(IDC)) scan_port_i (.link(link), .core_clk(core_clk), .resetn(resetn),
      .core_out(core_out), .pin_in(pin_in), .pin_out(pin_out), .prog_active(prog_active));
   scan_link_asserts #(.ID_CODE(IDC)) scan_link_asserts_i (.tck(link.tck), .tms(link.tms),
      .tdi(link.tdi), .trst_n(link.trst_n), .tdo(link.tdo), .tdo_oe_n(link.tdo_oe_n),
      .tdo_line(link.tdo_line));

   // core clock, 8 ns
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // low n bits set
   function automatic logic [31:0] mask(input int n);
      return (n >= 32) ? 32'hFFFF_FFFF : ((32'h1 << n) - 32'h1);
   endfunction

   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one command, held until taken, then bounded wait for the answer
   task automatic issue(input cmd_kind_type k, input int len, input logic [31:0] dat);
      int i;
      @(posedge core_clk);
      cmd_kind  <= k;
      cmd_len   <= 6'(len);
      cmd_data  <= dat;
      cmd_valid <= 1'b1;
      i = 0;
      do begin @(negedge core_clk); i++; end while (cmd_ready !== 1'b1 && i < 100);
      // a command never taken is a hang, not a pass
      if (cmd_ready !== 1'b1) begin
         n_mismatch++;
         wrap_up();
      end
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      i = 0;
      do begin @(negedge core_clk); i++; end while (rsp_valid !== 1'b1 && i < 2000);
      if (rsp_valid !== 1'b1) begin
         n_mismatch++;
         wrap_up();
      end
      // running budget of shift periods and pulse cycles
      // the reset walk itself spends six shift periods after the clear
      if (k == CMD_RESET) begin shifts = 6; pulses = 0; end
      if (k == CMD_IR) shifts += len + 6;
      if (k == CMD_DR) shifts += len + 5;
      if (k == CMD_PULSE_PROG) pulses += PP;
      if (k == CMD_PULSE_VERIFY) pulses += VP;
   endtask

   task automatic dr_check(input logic [3:0] op, input int len, input logic [31:0] exp);
      issue(CMD_IR, 4, 32'(op));
      issue(CMD_DR, len, $random(seed));
      compare(rsp_data & mask(len), exp);
   endtask

   initial begin
      resetn = 1'b0; cmd_valid = 1'b0; cmd_kind = CMD_RESET; cmd_len = 6'h00; cmd_data = 32'h0;
      core_out = $random(seed);
      pin_in = $random(seed);
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      issue(CMD_RESET, 1, 32'h0);
      issue(CMD_DR, 32, $random(seed));
      compare(rsp_data, IDC);
      // long instruction scans: capture pattern, then one-bit path codes
      foreach (ops[j]) begin
         issue(CMD_IR, 8, {24'h0, ops[j], 4'h5});
         compare(rsp_data & mask(8), 32'h51);
         d = $random(seed);
         issue(CMD_DR, 8, d);
         compare(rsp_data & mask(8), (d << 1) & mask(8));
      end
      // snapshot with preload, normal drive kept
      p = $random(seed);
      issue(CMD_IR, 4, 32'(`OP_SAMPLE));
      issue(CMD_DR, PINS, 32'(p));
      compare(rsp_data & mask(PINS), 32'(pin_in));
      compare(32'(pin_out), 32'(core_out));
      // external test drives the preload, then a new pattern
      issue(CMD_IR, 4, 32'(`OP_EXTEST));
      // new pin levels need four tck rises through the sync before capture
      q = $random(seed);
      @(posedge core_clk);
      pin_in <= $random(seed);
      repeat (24) @(negedge core_clk);
      compare(32'(pin_out), 32'(p));
      issue(CMD_DR, PINS, 32'(q));
      compare(rsp_data & mask(PINS), 32'(pin_in));
      repeat (10) @(negedge core_clk);
      compare(32'(pin_out), 32'(q));
      // erase, then both readback words show the erased value
      issue(CMD_IR, 4, 32'(`OP_ERASE));
      issue(CMD_DR, 1, 32'h0);
      issue(CMD_PULSE_PROG, 1, 32'h0);
      dr_check(`OP_USER, 32, `ERASED_WORD);
      dr_check(`OP_SIGN, 32, `ERASED_WORD);
      // program one word, verify it, read it as user code
      w = $random(seed);
      issue(CMD_IR, 4, 32'(`OP_ADDR));
      issue(CMD_DR, 4, 32'(`USER_WORD));
      issue(CMD_IR, 4, 32'(`OP_PROG));
      compare(32'(prog_active), 32'h1);
      issue(CMD_DR, 32, w);
      issue(CMD_PULSE_PROG, 1, 32'h0);
      dr_check(`OP_VERIFY, 32, w);
      issue(CMD_PULSE_VERIFY, 1, 32'h0);
      dr_check(`OP_USER, 32, w);
      compare(32'(prog_active), 32'h0);
      compare(shift_cnt, 32'(shifts));
      compare(budget, 32'(pulses + shifts * `TCK_DIV));
      wrap_up();
   end
endmodule // tb_boundary_scan_instruction_set
